// ---- hw/i2crs_top.sv ----
// Two-wire register target port: pin engine on the link clock, register
// access and write lock on the reference clock.
// Assumes the register file answers reads in the cycle reg_rd_o is high.
`timescale 1ns/1ps

module i2crs_top (
	// Reference clock domain
	input  wire logic                 ref_clk_i,
	input  wire logic                 resetn_i,
	input  wire logic                 ce_i,
	// Link clock domain
	input  wire logic                 lnk_clk_i,
	input  wire logic                 lnk_resetn_i,
	// Two-wire pins
	input  wire logic                 scl_i,
	input  wire logic                 sda_i,
	output logic                      sda_o,
	output logic                      sda_oe_n_o,
	// Register file side
	output logic                      reg_wr_o,
	output logic                      reg_rd_o,
	output i2crs_pkg::i2crs_req_s     reg_cmd_o,
	input  wire logic [31:0]          reg_rdata_i,
	output logic                      unlocked_o
);
	import i2crs_pkg::*;

	// ****************************************
	// Pin sampling
	// ****************************************
	logic         scl_s;
	logic         sda_s;
	logic         lnk_ce;
	logic         scl_d_ff;
	logic         sda_d_ff;

	i2crs_sync #(.W(3)) u_pin_sync (
		.clk_i    (lnk_clk_i),
		.resetn_i (lnk_resetn_i),
		.d_i      ({scl_i, sda_i, ce_i}),
		.q_o      ({scl_s, sda_s, lnk_ce})
	);

	wire start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
	wire stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
	wire scl_rise  = scl_s & ~scl_d_ff;
	wire scl_fall  = ~scl_s & scl_d_ff;

	// ****************************************
	// Link engine state
	// ****************************************
	i2crs_state_e state_ff;
	i2crs_state_e nxt_state;
	logic [3:0]   cnt_ff;
	logic [3:0]   nxt_cnt;
	logic [7:0]   sh_ff;
	logic [7:0]   nxt_sh;
	logic [7:0]   tx_ff;
	logic [7:0]   nxt_tx;
	logic         rw_ff;
	logic         nxt_rw;
	logic [1:0]   byte_ff;
	logic [1:0]   nxt_byte;
	logic [7:0]   raddr_ff;
	logic [7:0]   nxt_raddr;
	logic [31:0]  wword_ff;
	logic [31:0]  nxt_wword;
	logic [31:0]  rd_word_ff;
	logic         oe_n_ff;
	logic         nxt_oe_n;
	logic         mack_ff;
	logic         nxt_mack;
	logic         sda_ff;
	logic         launch;
	i2crs_req_s   launch_req;
	logic         cdc_busy;
	logic         cdc_done;
	logic [31:0]  cdc_rsp;

	wire          active    = (state_ff != ST_IDLE) && (state_ff != ST_IGNORE);
	wire [1:0]    byte_inc  = byte_ff + 2'h1;
	wire [7:0]    raddr_inc = raddr_ff + 8'h01;
	wire [7:0]    next_tx   = sel_byte(rd_word_ff, byte_inc);
	wire [7:0]    first_tx  = sel_byte(rd_word_ff, 2'h0);
	wire [2:0]    tx_idx    = 3'(4'h7 - cnt_ff);
	wire          own_addr  = (sh_ff[7:1] == DEV_ADDR);

	always_comb begin
		nxt_state  = state_ff;
		nxt_cnt    = cnt_ff;
		nxt_sh     = sh_ff;
		nxt_tx     = tx_ff;
		nxt_rw     = rw_ff;
		nxt_byte   = byte_ff;
		nxt_raddr  = raddr_ff;
		nxt_wword  = wword_ff;
		nxt_oe_n   = oe_n_ff;
		nxt_mack   = mack_ff;
		launch     = 1'b0;
		launch_req = '0;
		if (start_det) begin
			// Any start, repeated or not, restarts the byte sequence
			nxt_state = ST_ADDR;
			nxt_cnt   = CNT_RST;
			nxt_oe_n  = 1'b1;
		end else if (stop_det) begin
			nxt_state = ST_IDLE;
			nxt_cnt   = CNT_RST;
			nxt_oe_n  = 1'b1;
		end else if (scl_rise && active) begin
			// Sampled on the rising edge: data is stable while the clock is high
			if (cnt_ff < CNT_ACK) begin
				nxt_sh = {sh_ff[6:0], sda_s};
			end else begin
				nxt_mack = ~sda_s;
			end
			nxt_cnt = cnt_ff + 4'h1;
		end else if (scl_fall && active) begin
			if (cnt_ff == CNT_ACK) begin
				case (state_ff)
					ST_ADDR: begin
						if (own_addr) begin
							nxt_oe_n = 1'b0;
							nxt_rw   = sh_ff[0];
						end else begin
							nxt_state = ST_IGNORE;
							nxt_cnt   = CNT_RST;
						end
					end
					ST_REG: begin
						nxt_oe_n   = 1'b0;
						nxt_raddr  = sh_ff;
						// Fetch early so the first read byte is ready in time
						launch     = 1'b1;
						launch_req = '{wr: 1'b0, addr: sh_ff, data: WORD_RST};
					end
					ST_DATA: begin
						nxt_oe_n  = 1'b0;
						nxt_wword = {wword_ff[23:0], sh_ff};
						if (byte_ff == BYTE_LAST) begin
							launch     = 1'b1;
							launch_req = '{wr: 1'b1, addr: raddr_ff,
							               data: {wword_ff[23:0], sh_ff}};
						end
					end
					default: begin
						nxt_oe_n = 1'b1;
					end
				endcase
			end else if (cnt_ff == CNT_FRAME) begin
				nxt_cnt  = CNT_RST;
				nxt_oe_n = 1'b1;
				case (state_ff)
					ST_ADDR: begin
						if (rw_ff) begin
							nxt_state = ST_SEND;
							nxt_byte  = 2'h0;
							nxt_tx    = first_tx;
							nxt_oe_n  = first_tx[7];
						end else begin
							nxt_state = ST_REG;
						end
					end
					ST_REG: begin
						nxt_state = ST_DATA;
						nxt_byte  = 2'h0;
					end
					ST_DATA: begin
						nxt_byte = byte_inc;
						if (byte_ff == BYTE_LAST) begin
							nxt_raddr = raddr_inc;
						end
					end
					ST_SEND: begin
						if (mack_ff) begin
							nxt_byte = byte_inc;
							nxt_tx   = next_tx;
							nxt_oe_n = next_tx[7];
							if (byte_inc == BYTE_LAST) begin
								// Last byte is latched; refill the word behind it
								nxt_raddr  = raddr_inc;
								launch     = 1'b1;
								launch_req = '{wr: 1'b0, addr: raddr_inc, data: WORD_RST};
							end
						end else begin
							nxt_state = ST_IGNORE;
						end
					end
					default: begin
						nxt_state = ST_IDLE;
					end
				endcase
			end else if (state_ff == ST_SEND) begin
				nxt_oe_n = tx_ff[tx_idx];
			end
		end
	end

	// ****************************************
	// Link engine registers
	// ****************************************
	always_ff @(posedge lnk_clk_i) begin
		if (!lnk_resetn_i) begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
			state_ff <= ST_IDLE;
			cnt_ff   <= CNT_RST;
			sh_ff    <= BYTE_RST;
			tx_ff    <= BYTE_RST;
			rw_ff    <= 1'b0;
			byte_ff  <= 2'h0;
			raddr_ff <= BYTE_RST;
			wword_ff <= WORD_RST;
			oe_n_ff  <= 1'b1;
			mack_ff  <= 1'b0;
		end else if (lnk_ce) begin
			scl_d_ff <= scl_s;
			sda_d_ff <= sda_s;
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			sh_ff    <= nxt_sh;
			tx_ff    <= nxt_tx;
			rw_ff    <= nxt_rw;
			byte_ff  <= nxt_byte;
			raddr_ff <= nxt_raddr;
			wword_ff <= nxt_wword;
			oe_n_ff  <= nxt_oe_n;
			mack_ff  <= nxt_mack;
		end
	end

	// Read word is refreshed by every handshake answer, write answers included
	always_ff @(posedge lnk_clk_i) begin
		if (!lnk_resetn_i) begin
			rd_word_ff <= WORD_RST;
		end else if (cdc_done) begin
			rd_word_ff <= cdc_rsp;
		end
	end

	// Open drain: only ever pulls low, never drives high
	always_ff @(posedge lnk_clk_i) begin
		if (!lnk_resetn_i) begin
			sda_ff <= 1'b0;
		end else begin
			sda_ff <= 1'b0;
		end
	end

	assign sda_o      = sda_ff;
	assign sda_oe_n_o = oe_n_ff;

	// ****************************************
	// Domain crossing
	// ****************************************
	logic        dst_valid;
	i2crs_req_s  dst_req;
	logic        pend_ff;

	// A request arriving while one is in flight is dropped; spacing on the bus
	// is many link cycles, so this only happens at absurd bus rates.
	i2crs_hs_cdc #(.QW(REQ_W), .RW(32)) u_cdc (
		.src_clk_i    (lnk_clk_i),
		.src_resetn_i (lnk_resetn_i),
		.src_ce_i     (lnk_ce),
		.src_start_i  (launch & lnk_ce),
		.src_req_i    (launch_req),
		.src_busy_o   (cdc_busy),
		.src_done_o   (cdc_done),
		.src_rsp_o    (cdc_rsp),
		.dst_clk_i    (ref_clk_i),
		.dst_resetn_i (resetn_i),
		.dst_ce_i     (ce_i),
		.dst_valid_o  (dst_valid),
		.dst_req_o    (dst_req),
		.dst_done_i   (pend_ff),
		.dst_rsp_i    (reg_rdata_i)
	);

	// ****************************************
	// Register side and write lock
	// ****************************************
	logic        unlocked_ff;
	logic        reg_wr_ff;
	logic        reg_rd_ff;
	i2crs_req_s  cmd_ff;

	wire is_unlock = dst_req.wr && (dst_req.addr == UNLOCK_ADDR)
	                 && (dst_req.data == UNLOCK_DATA);
	wire wr_allow  = unlocked_ff || (dst_req.addr == SLEEP_ADDR);

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			unlocked_ff <= 1'b0;
			reg_wr_ff   <= 1'b0;
			reg_rd_ff   <= 1'b0;
			pend_ff     <= 1'b0;
			cmd_ff      <= '0;
		end else if (ce_i) begin
			pend_ff   <= dst_valid;
			reg_wr_ff <= dst_valid & dst_req.wr & wr_allow;
			reg_rd_ff <= dst_valid & ~dst_req.wr;
			if (dst_valid) begin
				cmd_ff <= dst_req;
			end
			// Only reset clears it; no bus command can
			if (dst_valid && is_unlock) begin
				unlocked_ff <= 1'b1;
			end
		end
	end

	assign reg_wr_o   = reg_wr_ff;
	assign reg_rd_o   = reg_rd_ff;
	assign reg_cmd_o  = cmd_ff;
	assign unlocked_o = unlocked_ff;

endmodule : i2crs_top

// ---- hw/i2crs_pkg.sv ----
// Shared constants, types and helpers for the two-wire register target port.
// Assumes one pin-side clock domain and one register-side clock domain.

package i2crs_pkg;

	// ****************************************
	// Bus constants
	// ****************************************
	localparam logic [6:0]  DEV_ADDR      = 7'h6e;
	localparam logic [7:0]  UNLOCK_ADDR   = 8'h35;
	localparam logic [31:0] UNLOCK_DATA   = 32'h2c413534;
	localparam logic [7:0]  SLEEP_ADDR    = 8'h27;
	localparam logic [3:0]  CNT_ACK       = 4'h8;
	localparam logic [3:0]  CNT_FRAME     = 4'h9;
	localparam logic [1:0]  BYTE_LAST     = 2'h3;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [3:0]  CNT_RST       = 4'h0;
	localparam logic [7:0]  BYTE_RST      = 8'h00;
	localparam logic [31:0] WORD_RST      = 32'h0000_0000;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_ADDR   = 3'b001,
		ST_REG    = 3'b010,
		ST_DATA   = 3'b011,
		ST_SEND   = 3'b100,
		ST_IGNORE = 3'b101
	} i2crs_state_e;

	typedef struct packed {
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] data;
	} i2crs_req_s;

	localparam int REQ_W = 41;

	// Byte 0 is bits 31:24, sent first
	function automatic logic [7:0] sel_byte(input logic [31:0] word, input logic [1:0] idx);
		sel_byte = word[8'(31 - 8 * idx) -: 8];
	endfunction : sel_byte

endpackage : i2crs_pkg

// ---- hw/i2crs_sync.sv ----
// Two-flop level synchroniser, one bit per lane.
// Assumes the inputs are levels from another clock domain or from pins.
`timescale 1ns/1ps

module i2crs_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	// Lanes
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			meta_ff <= '0;
			q_ff    <= '0;
		end else begin
			meta_ff <= d_i;
			q_ff    <= meta_ff;
		end
	end

	assign q_o = q_ff;

endmodule : i2crs_sync

// ---- hw/i2crs_hs_cdc.sv ----
// Toggle handshake carrying one request word across and one answer word back.
// Assumes the source holds off new requests while busy_o is high.
`timescale 1ns/1ps

module i2crs_hs_cdc #(
	parameter int QW = 8,
	parameter int RW = 8
) (
	// Source side
	input  wire logic          src_clk_i,
	input  wire logic          src_resetn_i,
	input  wire logic          src_ce_i,
	input  wire logic          src_start_i,
	input  wire logic [QW-1:0] src_req_i,
	output logic               src_busy_o,
	output logic               src_done_o,
	output logic      [RW-1:0] src_rsp_o,
	// Destination side
	input  wire logic          dst_clk_i,
	input  wire logic          dst_resetn_i,
	input  wire logic          dst_ce_i,
	output logic               dst_valid_o,
	output logic      [QW-1:0] dst_req_o,
	input  wire logic          dst_done_i,
	input  wire logic [RW-1:0] dst_rsp_i
);
	logic          req_tgl_ff;
	logic [QW-1:0] req_ff;
	logic          ack_seen_ff;
	logic          ack_s;
	logic          req_s;
	logic          req_seen_ff;
	logic          ack_tgl_ff;
	logic [RW-1:0] rsp_ff;

	// Payload is held until the answer toggles back, so it is stable when sampled
	always_ff @(posedge src_clk_i) begin
		if (!src_resetn_i) begin
			req_tgl_ff  <= 1'b0;
			req_ff      <= '0;
			ack_seen_ff <= 1'b0;
		end else if (src_ce_i) begin
			ack_seen_ff <= ack_s;
			if (src_start_i && !src_busy_o) begin
				req_tgl_ff <= ~req_tgl_ff;
				req_ff     <= src_req_i;
			end
		end
	end

	i2crs_sync #(.W(1)) u_ack_sync (
		.clk_i    (src_clk_i),
		.resetn_i (src_resetn_i),
		.d_i      (ack_tgl_ff),
		.q_o      (ack_s)
	);

	assign src_busy_o = req_tgl_ff ^ ack_seen_ff;
	assign src_done_o = src_ce_i & (ack_s ^ ack_seen_ff);
	assign src_rsp_o  = rsp_ff;

	i2crs_sync #(.W(1)) u_req_sync (
		.clk_i    (dst_clk_i),
		.resetn_i (dst_resetn_i),
		.d_i      (req_tgl_ff),
		.q_o      (req_s)
	);

	always_ff @(posedge dst_clk_i) begin
		if (!dst_resetn_i) begin
			req_seen_ff <= 1'b0;
			ack_tgl_ff  <= 1'b0;
			rsp_ff      <= '0;
		end else if (dst_ce_i) begin
			req_seen_ff <= req_s;
			if (dst_done_i) begin
				ack_tgl_ff <= ~ack_tgl_ff;
				rsp_ff     <= dst_rsp_i;
			end
		end
	end

	assign dst_valid_o = dst_ce_i & (req_s ^ req_seen_ff);
	assign dst_req_o   = req_ff;

endmodule : i2crs_hs_cdc

// ---- dv/i2crs_top_sva.sv ----
// Checker for the two-wire register target port, bound to its top.
// Assumes both resets are synchronous and active low.
`timescale 1ns/1ps

module i2crs_top_sva
	import i2crs_pkg::*;
(
	// Clocks and resets
	input wire logic                  ref_clk_i,
	input wire logic                  resetn_i,
	input wire logic                  lnk_clk_i,
	input wire logic                  lnk_resetn_i,
	// Pins
	input wire logic                  scl_i,
	input wire logic                  sda_o,
	input wire logic                  sda_oe_n_o,
	// Register side
	input wire logic                  reg_wr_o,
	input wire logic                  reg_rd_o,
	input wire i2crs_pkg::i2crs_req_s reg_cmd_o,
	input wire logic                  unlocked_o
);
	// ********
	// Pin side
	// ********
	pull_low_a: assert property (@(posedge lnk_clk_i) disable iff (!lnk_resetn_i)
		!sda_oe_n_o |-> sda_o == 1'b0) else $error("data pin driven high");
	stable_high_a: assert property (@(posedge lnk_clk_i) disable iff (!lnk_resetn_i)
		scl_i && $past(scl_i) |-> $stable(sda_oe_n_o)) else $error("data moved in high");
	no_start_a: assert property (@(posedge lnk_clk_i) disable iff (!lnk_resetn_i)
		$fell(sda_oe_n_o) |-> !scl_i) else $error("target pulled data in high");
	ack_hold_a: assert property (@(posedge lnk_clk_i) disable iff (!lnk_resetn_i)
		$fell(sda_oe_n_o) |-> !sda_oe_n_o [*4]) else $error("drive too short");

	// ********
	// Register side
	// ********
	wr_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		reg_wr_o |-> reg_cmd_o.wr && !reg_rd_o ##1 !reg_wr_o) else $error("bad write strobe");
	rd_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		reg_rd_o |-> !reg_cmd_o.wr ##1 !reg_rd_o) else $error("bad read strobe");
	lock_gate_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		reg_wr_o && !unlocked_o |-> reg_cmd_o.addr == SLEEP_ADDR) else $error("locked write");
	unlock_code_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		$rose(unlocked_o) |-> reg_cmd_o.addr == UNLOCK_ADDR && reg_cmd_o.data == UNLOCK_DATA)
		else $error("unlock without code");
	unlock_keep_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		unlocked_o |=> unlocked_o) else $error("unlock lost");
endmodule : i2crs_top_sva

bind i2crs_top i2crs_top_sva u_sva (
	.ref_clk_i, .resetn_i, .lnk_clk_i, .lnk_resetn_i, .scl_i, .sda_o,
	.sda_oe_n_o, .reg_wr_o, .reg_rd_o, .reg_cmd_o, .unlocked_o
);

// ---- dv/i2crs_master_model.sv ----
// Bus controller model: drives the clock line, pulls the data line low.
// Assumes pull-ups on both lines; sda_i is the resolved wire.
`timescale 1ns/1ps

module i2crs_master_model (
	// Bus pins
	output logic      scl_o,
	output logic      sda_oe_n_o,
	input  wire logic sda_i
);
	// ********
	// Bit timing, 1 us a bit
	// ********
	initial begin
		scl_o      = 1'b1;
		sda_oe_n_o = 1'b1;
	end

	// Data moves well after the clock fall, so it never looks like start or stop
	task automatic bit_io(input logic b, output logic s);
		#160;
		sda_oe_n_o = b;
		#340;
		scl_o = 1'b1;
		#250;
		s = sda_i;
		#250;
		scl_o = 1'b0;
	endtask : bit_io

	// Also a repeated start
	task automatic bus_start();
		#160;
		sda_oe_n_o = 1'b1;
		#340;
		scl_o = 1'b1;
		#500;
		sda_oe_n_o = 1'b0;
		#500;
		scl_o = 1'b0;
	endtask : bus_start

	task automatic bus_stop();
		#160;
		sda_oe_n_o = 1'b0;
		#340;
		scl_o = 1'b1;
		#500;
		sda_oe_n_o = 1'b1;
		#500;
	endtask : bus_stop

	task automatic byte_io(input logic [7:0] tx, input logic ack_tx,
		output logic [7:0] rx, output logic ack_rx);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(ack_tx, ack_rx);
	endtask : byte_io
endmodule : i2crs_master_model

// ---- dv/i2crs_top_test.sv ----
// Self-checking bench: controller model on the pins, word store on the register side.
// Assumes the checker binds itself to the top.
`timescale 1ns/1ps

module i2crs_top_test;
	import i2crs_pkg::*;

	logic        ref_clk_i;
	logic        resetn_i;
	logic        ce_i;
	logic        lnk_clk_i;
	logic        lnk_resetn_i;
	logic        scl;
	logic        mst_sda_oe_n;
	wire logic   sda;
	logic        sda_o;
	logic        sda_oe_n_o;
	logic        reg_wr_o;
	logic        reg_rd_o;
	i2crs_req_s  reg_cmd_o;
	logic [31:0] reg_rdata_i;
	logic        unlocked_o;
	i2crs_req_s  exp_q[$];
	int          mismatches = 0;
	int          check_count = 0;
	int          seed = 72;
	logic [31:0] w0;
	logic [31:0] w1;
	logic [7:0]  ra;
	logic [7:0]  last_fetch = 8'h00;

	// ********
	// Clocks, bus wire, store
	// ********
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		lnk_clk_i = 1'b0;
		#7;
		forever #15 lnk_clk_i = ~lnk_clk_i;
	end

	function automatic logic [31:0] rd_word(input logic [7:0] a);
		return {a, ~a, a ^ 8'h5a, 8'h3c};
	endfunction : rd_word

	// Pull-up: low if either side pulls
	assign sda = mst_sda_oe_n & (sda_oe_n_o | sda_o);
	assign reg_rdata_i = rd_word(reg_cmd_o.addr);

	i2crs_top DUT (
		.ref_clk_i, .resetn_i, .ce_i, .lnk_clk_i, .lnk_resetn_i,
		.scl_i (scl),
		.sda_i (sda),
		.sda_o, .sda_oe_n_o, .reg_wr_o, .reg_rd_o, .reg_cmd_o, .reg_rdata_i, .unlocked_o
	);
	i2crs_master_model mst (
		.scl_o      (scl),
		.sda_oe_n_o (mst_sda_oe_n),
		.sda_i      (sda)
	);

	// ********
	// Checking
	// ********
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Strobes sampled mid-cycle, away from the launching edge
	always @(negedge ref_clk_i) begin
		if (reg_wr_o === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk("unexpected write", 1'b0, 1'b1);
			end else begin
				chk("write command", exp_q.pop_front(), reg_cmd_o);
			end
		end
		if (reg_rd_o === 1'b1) begin
			last_fetch = reg_cmd_o.addr;
		end
	end

	task automatic drain();
		for (int t = 0; t < 400 && exp_q.size() != 0; t++) begin
			@(posedge ref_clk_i);
		end
		chk("writes left", 0, exp_q.size());
		if (exp_q.size() != 0) begin
			tally_and_finish();
		end
	endtask : drain

	task automatic put(input logic [7:0] b, input logic ack_exp);
		logic [7:0] rx;
		logic       ak;
		mst.byte_io(b, 1'b1, rx, ak);
		chk("ack bit", ack_exp, ak);
	endtask : put

	task automatic write_regs(input logic [7:0] a, input logic [31:0] x0,
		input logic [31:0] x1, input int nb, input logic fwd);
		logic [31:0] wd;
		for (int k = 0; k < nb / 4; k++) begin
			if (fwd) begin
				exp_q.push_back('{1'b1, a + 8'(k), (k == 0) ? x0 : x1});
			end
		end
		mst.bus_start();
		put({DEV_ADDR, 1'b0}, 1'b0);
		put(a, 1'b0);
		for (int i = 0; i < nb; i++) begin
			wd = (i < 4) ? x0 : x1;
			put(wd[31 - 8 * (i % 4) -: 8], 1'b0);
		end
		mst.bus_stop();
		drain();
	endtask : write_regs

	task automatic read_regs(input logic [7:0] a, input int n);
		logic [7:0]  rx;
		logic        ak;
		logic [31:0] wd;
		mst.bus_start();
		put({DEV_ADDR, 1'b0}, 1'b0);
		put(a, 1'b0);
		mst.bus_start();
		put({DEV_ADDR, 1'b1}, 1'b0);
		for (int i = 0; i < 4 * n; i++) begin
			wd = rd_word(a + 8'(i / 4));
			mst.byte_io(8'hff, i == 4 * n - 1, rx, ak);
			chk("read byte", wd[31 - 8 * (i % 4) -: 8], rx);
		end
		mst.bus_stop();
		chk("data released", 1'b1, sda_oe_n_o);
		chk("fetch address", 8'(a + 8'(n)), last_fetch);
	endtask : read_regs

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish

	// ********
	// Scenarios
	// ********
	initial begin
		resetn_i     = 1'b0;
		lnk_resetn_i = 1'b0;
		ce_i         = 1'b1;
		repeat (16) @(posedge ref_clk_i);
		#1;
		resetn_i     = 1'b1;
		lnk_resetn_i = 1'b1;
		repeat (20) @(posedge ref_clk_i);
		w0 = $random(seed);
		w1 = $random(seed);
		ra = 8'($random(seed)) & 8'h7f;
		chk("lock flag", 1'b0, unlocked_o);
		write_regs(8'h10, w0, w1, 4, 1'b0);
		write_regs(SLEEP_ADDR, w1, w0, 4, 1'b1);
		$display("test locked writes done");
		mst.bus_start();
		put({7'h21, 1'b0}, 1'b1);
		put(8'h10, 1'b1);
		mst.bus_stop();
		$display("test foreign address done");
		mst.bus_start();
		put({DEV_ADDR, 1'b0}, 1'b0);
		put(SLEEP_ADDR, 1'b0);
		put(8'haa, 1'b0);
		write_regs(SLEEP_ADDR, w0, w1, 4, 1'b1);
		$display("test restart done");
		read_regs(ra, 2);
		$display("test read done");
		write_regs(UNLOCK_ADDR, UNLOCK_DATA, w1, 4, 1'b0);
		for (int t = 0; t < 400 && unlocked_o !== 1'b1; t++) begin
			@(posedge ref_clk_i);
		end
		chk("lock flag", 1'b1, unlocked_o);
		if (unlocked_o !== 1'b1) begin
			tally_and_finish();
		end
		write_regs(8'h10, w0, w1, 8, 1'b1);
		write_regs(UNLOCK_ADDR, w1, w0, 4, 1'b1);
		chk("lock flag", 1'b1, unlocked_o);
		$display("test unlock done");
		tally_and_finish();
	end
endmodule : i2crs_top_test
